// ==== pkg/siac_defs.vh ====
// Register offsets, field positions and reset values for the slot interrupt block
`ifndef SIAC_DEFS_VH
`define SIAC_DEFS_VH

`define SIAC_ADDR_W 16
`define SIAC_DATA_W 16
`define SIAC_SLOTS 12

// Register offsets
`define SIAC_OFS_STATUS 16'h0001
`define SIAC_OFS_ACLEAR 16'h0007
`define SIAC_OFS_IRQ1_EN 16'h0014

// Shared FIFO field positions (status and enable registers; autoclear has the level bit only)
`define SIAC_BIT_FIFO_LEVEL 15
`define SIAC_BIT_FIFO_UNDER 14
`define SIAC_BIT_FIFO_OVER 13
`define SIAC_BIT_RSVD 12

// Slot fields
`define SIAC_ACLR_SLOT_LO 0
`define SIAC_ACLR_SLOT_HI 10
`define SIAC_EN_SLOT_LO 4
`define SIAC_EN_SLOT_HI 11

// Writable masks and reset values
`define SIAC_ACLEAR_MASK 16'h87ff
`define SIAC_ACLEAR_RST 16'h87ff
`define SIAC_IRQ1_EN_MASK 16'heff0
`define SIAC_IRQ1_EN_RST 16'h0000
`define SIAC_STATUS_MASK 16'hefff
`endif

// ==== hw/siac_core.v ====
// Slot data-ready and FIFO interrupt flags with enable gating and autoclear
`timescale 1ns/1ps
`include "siac_defs.vh"

module siac_core #(
  parameter ADDR_W = `SIAC_ADDR_W,
  parameter DATA_W = `SIAC_DATA_W,
  parameter SLOTS = `SIAC_SLOTS
) (
  input wire clk,
  input wire rst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  output reg [DATA_W-1:0] reg_rdata_q,
  output reg reg_rd_valid_q,
  input wire [SLOTS-1:0] slot_ready_set,
  input wire [SLOTS-1:0] slot_data_rd,
  input wire fifo_level_set,
  input wire fifo_under_set,
  input wire fifo_over_set,
  input wire fifo_rd,
  output reg irq1_q
);

  reg [DATA_W-1:0] aclear_q;
  reg [DATA_W-1:0] aclear_d;
  reg [DATA_W-1:0] irq1_en_q;
  reg [DATA_W-1:0] irq1_en_d;
  reg [DATA_W-1:0] set_vec;
  reg [DATA_W-1:0] clr_vec;
  reg [DATA_W-1:0] rd_mux;
  wire [DATA_W-1:0] status_q;

  wire wr_aclear = reg_wr_en && (reg_addr == `SIAC_OFS_ACLEAR);
  wire wr_en_reg = reg_wr_en && (reg_addr == `SIAC_OFS_IRQ1_EN);
  wire wr_status = reg_wr_en && (reg_addr == `SIAC_OFS_STATUS);

  // Autoclear fields, slots A to K and the FIFO threshold
  wire slot_a_ready_selfclear_en = aclear_q[0];
  wire slot_b_ready_selfclear_en = aclear_q[1];
  wire slot_c_ready_selfclear_en = aclear_q[2];
  wire slot_d_ready_selfclear_en = aclear_q[3];
  wire slot_e_ready_selfclear_en = aclear_q[4];
  wire slot_f_ready_selfclear_en = aclear_q[5];
  wire slot_g_ready_selfclear_en = aclear_q[6];
  wire slot_h_ready_selfclear_en = aclear_q[7];
  wire slot_i_ready_selfclear_en = aclear_q[8];
  wire slot_j_ready_selfclear_en = aclear_q[9];
  wire slot_k_ready_selfclear_en = aclear_q[10];
  wire fifo_level_selfclear_en = aclear_q[`SIAC_BIT_FIFO_LEVEL];
  wire [10:0] slot_selfclear_en = {slot_k_ready_selfclear_en, slot_j_ready_selfclear_en,
    slot_i_ready_selfclear_en, slot_h_ready_selfclear_en, slot_g_ready_selfclear_en,
    slot_f_ready_selfclear_en, slot_e_ready_selfclear_en, slot_d_ready_selfclear_en,
    slot_c_ready_selfclear_en, slot_b_ready_selfclear_en, slot_a_ready_selfclear_en};

  // First interrupt enable fields
  wire irq1_fifo_level_en = irq1_en_q[`SIAC_BIT_FIFO_LEVEL];
  wire irq1_fifo_under_en = irq1_en_q[`SIAC_BIT_FIFO_UNDER];
  wire irq1_fifo_over_en = irq1_en_q[`SIAC_BIT_FIFO_OVER];
  wire irq1_slot_l_ready_en = irq1_en_q[11];
  wire irq1_slot_k_ready_en = irq1_en_q[10];
  wire irq1_slot_j_ready_en = irq1_en_q[9];
  wire irq1_slot_i_ready_en = irq1_en_q[8];
  wire irq1_slot_h_ready_en = irq1_en_q[7];
  wire irq1_slot_g_ready_en = irq1_en_q[6];
  wire irq1_slot_f_ready_en = irq1_en_q[5];
  wire irq1_slot_e_ready_en = irq1_en_q[4];
  // Slots A to D have no enable on this output, so they never raise it
  wire [SLOTS-1:0] slot_ready_en = {irq1_slot_l_ready_en, irq1_slot_k_ready_en,
    irq1_slot_j_ready_en, irq1_slot_i_ready_en, irq1_slot_h_ready_en, irq1_slot_g_ready_en,
    irq1_slot_f_ready_en, irq1_slot_e_ready_en, 4'h0};

  // Sticky flags
  wire fifo_level_flag = status_q[`SIAC_BIT_FIFO_LEVEL];
  wire fifo_under_flag = status_q[`SIAC_BIT_FIFO_UNDER];
  wire fifo_over_flag = status_q[`SIAC_BIT_FIFO_OVER];
  wire [SLOTS-1:0] slot_ready_flag = status_q[SLOTS-1:0];

  // Gated interrupt sources
  wire fifo_level_irq = fifo_level_flag & irq1_fifo_level_en;
  wire fifo_under_irq = fifo_under_flag & irq1_fifo_under_en;
  wire fifo_over_irq = fifo_over_flag & irq1_fifo_over_en;
  wire [SLOTS-1:0] slot_ready_irq = slot_ready_flag & slot_ready_en;
  wire irq1_d = fifo_level_irq | fifo_under_irq | fifo_over_irq | (|slot_ready_irq);

  // Control registers; unwritable bits are held at zero by the mask
  always @* begin
    aclear_d = aclear_q;
    irq1_en_d = irq1_en_q;
    if (wr_aclear) begin
      aclear_d = reg_wdata & `SIAC_ACLEAR_MASK;
    end
    if (wr_en_reg) begin
      irq1_en_d = reg_wdata & `SIAC_IRQ1_EN_MASK;
    end
  end

  // Flag set and clear sources
  always @* begin
    set_vec = {DATA_W{1'b0}};
    clr_vec = {DATA_W{1'b0}};
    set_vec[SLOTS-1:0] = slot_ready_set;
    set_vec[`SIAC_BIT_FIFO_LEVEL] = fifo_level_set;
    set_vec[`SIAC_BIT_FIFO_UNDER] = fifo_under_set;
    set_vec[`SIAC_BIT_FIFO_OVER] = fifo_over_set;
    // Slot L has no autoclear bit, so it only clears by write-one
    clr_vec[`SIAC_ACLR_SLOT_HI:`SIAC_ACLR_SLOT_LO] =
      slot_data_rd[`SIAC_ACLR_SLOT_HI:`SIAC_ACLR_SLOT_LO] & slot_selfclear_en;
    clr_vec[`SIAC_BIT_FIFO_LEVEL] = fifo_rd & fifo_level_selfclear_en;
    if (wr_status) begin
      clr_vec = clr_vec | (reg_wdata & `SIAC_STATUS_MASK);
    end
  end

  // One sticky flag per implemented status bit; the gap bit stays zero
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_flag
      if (((`SIAC_STATUS_MASK >> gi) & 16'h0001) != 16'h0000) begin : g_live
        siac_flag_cell flag_cell_inst (
          .clk(clk),
          .rst_n(rst_n),
          .set(set_vec[gi]),
          .clr(clr_vec[gi]),
          .flag_q(status_q[gi])
        );
      end else begin : g_tied
        assign status_q[gi] = 1'b0;
      end
    end
  endgenerate

  always @* begin
    case (reg_addr)
      `SIAC_OFS_STATUS: rd_mux = status_q;
      `SIAC_OFS_ACLEAR: rd_mux = aclear_q;
      `SIAC_OFS_IRQ1_EN: rd_mux = irq1_en_q;
      default: rd_mux = {DATA_W{1'b0}};
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aclear_q <= `SIAC_ACLEAR_RST;
      irq1_en_q <= `SIAC_IRQ1_EN_RST;
    end else begin
      aclear_q <= aclear_d;
      irq1_en_q <= irq1_en_d;
    end
  end

  // Read port: a read in the cycle of a write returns the old value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= {DATA_W{1'b0}};
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // Registered so the pin is glitch free; it trails the flags by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq1_q <= 1'b0;
    end else begin
      irq1_q <= irq1_d;
    end
  end

endmodule // siac_core

// Sticky flag: a set in the clearing cycle wins
module siac_flag_cell (
  input wire clk,
  input wire rst_n,
  input wire set,
  input wire clr,
  output reg flag_q
);

  reg flag_d;

  always @* begin
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    // Keeps an event that lands on the clear
    if (set) begin
      flag_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // siac_flag_cell

// ==== test/siac_monitor.sv ====
// Port assertions for siac_core
`timescale 1ns/1ps
module siac_monitor (input wire clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid_q, fifo_rd,
  irq1_q, fifo_level_set, fifo_under_set, fifo_over_set, input wire [15:0] reg_addr,
  reg_rdata_q, input wire [11:0] slot_ready_set, slot_data_rd);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire re = reg_rd_en && reg_addr == 16'h14, ra = reg_rd_en && reg_addr == 16'h7;
  wire cl = reg_wr_en || fifo_rd || |slot_data_rd;
  // Writes may unmask a flag, so they count as a cause
  wire sw = reg_wr_en || fifo_level_set || fifo_under_set || fifo_over_set || |slot_ready_set;
  rsvd_bit_a: assert property (re |=> !reg_rdata_q[12]) else $error("bit 12");
  en_low_a: assert property (re |=> reg_rdata_q[3:0] == 4'h0) else $error("low");
  ac_gap_a: assert property (ra |=> reg_rdata_q[14:11] == 4'h0) else $error("gap");
  rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid_q) else $error("valid");
  irq_rise_a: assert property ($rose(irq1_q) |-> $past(sw, 2)) else $error("rise");
  irq_fall_a: assert property ($fell(irq1_q) |-> $past(cl, 2)) else $error("fall");
  irq_hold_a: assert property (!cl ##1 irq1_q |=> irq1_q) else $error("hold");
  irq_idle_a: assert property (!sw ##1 !irq1_q |=> !irq1_q) else $error("idle");
  cover property (ra ##1 reg_rdata_q == 16'h87ff);
  cover property (fifo_rd ##2 $fell(irq1_q));
  cover property (|slot_data_rd ##2 $fell(irq1_q));
endmodule // siac_monitor

// ==== test/siac_host.sv ====
// Host model: reads the FIFO every other cycle while irq1 is high
`timescale 1ns/1ps
module siac_host (input wire clk, rst_n, irq1_q, output reg fifo_rd);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) fifo_rd <= 1'b0;
    else fifo_rd <= irq1_q && !fifo_rd;
  end
endmodule // siac_host

// ==== test/siac_core_test.sv ====
// Random and corner tests for siac_core
`timescale 1ns/1ps
module siac_core_test;
  reg clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0;
  reg [15:0] reg_addr = 0, reg_wdata = 0, s = 0, c = 0, d, b;
  wire [15:0] reg_rdata_q;
  wire reg_rd_valid_q, irq1_q, fifo_rd, fifo_level_set = s[15], fifo_under_set = s[14];
  wire fifo_over_set = s[13];
  wire [11:0] slot_ready_set = s[11:0], slot_data_rd = c[11:0];
  integer num_errors = 0, num_checks = 0, i, seed = 32'he46a4d1f;
  always #2.5 clk = ~clk;
  siac_core siac_core_inst (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rd_valid_q(reg_rd_valid_q),
    .slot_ready_set(slot_ready_set), .slot_data_rd(slot_data_rd),
    .fifo_level_set(fifo_level_set), .fifo_under_set(fifo_under_set),
    .fifo_over_set(fifo_over_set), .fifo_rd(fifo_rd), .irq1_q(irq1_q));
  siac_host siac_host_inst (.clk(clk), .rst_n(rst_n), .irq1_q(irq1_q), .fifo_rd(fifo_rd));
  function [15:0] ex(input [15:0] e, f); ex = |(e & f & 16'heff0); endfunction
  task k(input [15:0] v, e); num_checks++;
    if (v !== e) begin num_errors++; $display("[FAIL] %0t %h %h", $time, v, e); end endtask
  task t(input [15:0] a, v, input w);
    @(posedge clk) {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} <= {w, !w, a, v};
    @(posedge clk) {reg_wr_en, reg_rd_en} <= 2'b0;
    #1 k(reg_rd_valid_q, !w);
    if (!w) k(reg_rdata_q, v);
  endtask
  task p(input [15:0] x, y, e);
    @(posedge clk) {s, c} <= {x, y};
    @(posedge clk) {s, c} <= 32'h0;
    repeat (2) @(posedge clk); #1 k(irq1_q, e);
  endtask
  task print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish; endtask
  initial begin
    repeat (20) @(posedge clk); rst_n <= 1'b1;
    t(16'h7, 16'h87ff, 0); t(16'h14, 0, 0);
    for (i = 0; i < 16; i++) begin
      d = $random(seed); b = 16'h1 << i;
      t(16'h14, d, 1); t(16'h14, d & 16'heff0, 0);
      t(16'h7, d, 1); t(16'h7, d & 16'h87ff, 0);
      p(b, 0, ex(d, b));
      p(0, b, ex(d, b & ~(d & 16'h87ff)));
      t(16'h1, 16'hffff, 1);
    end
    print_verdict;
  end
  initial begin #40000; num_errors++; print_verdict; end
endmodule // siac_core_test
bind siac_core siac_monitor siac_monitor_inst (.clk(clk), .rst_n(rst_n),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_valid_q(reg_rd_valid_q),
  .fifo_rd(fifo_rd), .irq1_q(irq1_q), .fifo_level_set(fifo_level_set),
  .fifo_under_set(fifo_under_set), .fifo_over_set(fifo_over_set), .reg_addr(reg_addr),
  .reg_rdata_q(reg_rdata_q), .slot_ready_set(slot_ready_set), .slot_data_rd(slot_data_rd));
